// File: core/sec_consts.svh
// Register offsets, field positions, reset values and timing counts of the sleep entry control.
`ifndef SEC_CONSTS_SVH
`define SEC_CONSTS_SVH

// Register byte offsets.
`define SEC_OFF_CTRL_ONE    12'h000
`define SEC_OFF_CTRL_TWO    12'h004
`define SEC_OFF_STATUS      12'h008
`define SEC_OFF_WAKE_EN     12'h00C
`define SEC_OFF_TYPE_MAP    12'h010
`define SEC_OFF_FW_CMD      12'h014

// Control register fields.
`define SEC_TYPE_LSB        10
`define SEC_TYPE_MSB        12
`define SEC_ENABLE_BIT      13

// Status register fields.
`define SEC_STS_WAKE_BIT    15
`define SEC_STS_ASLEEP_BIT  0
`define SEC_STS_STATE_LSB   1

// Number of wake event inputs and sleeping states.
`define SEC_WAKE_NUM        8
`define SEC_STATE_NUM       4

// Default type map: codes 1..4 are valid and all select state 0, others unimplemented.
`define SEC_TYPE_MAP_RESET  32'h0000_001E
`define SEC_FW_HIB_VALUE    8'hA5

// Sequencing step time and its cycle count at 20 MHz.
`define SEC_CLK_HZ          20000000
`define SEC_STEP_NS         500
`define SEC_STEP_CYCLES     ((`SEC_STEP_NS * (`SEC_CLK_HZ / 1000000) + 999) / 1000)

// Bus responses.
`define SEC_RESP_OKAY       2'h0
`define SEC_RESP_SLVERR     2'h2

`endif

// File: core/sec_pkg.sv
// Types shared by the sleep entry control modules.
package sec_pkg;

	// Sequencer phases.
	typedef enum logic [2:0] {
		SEC_WORKING,
		SEC_HALT_CPU,
		SEC_STOP_CLK,
		SEC_POWER_OFF,
		SEC_ASLEEP,
		SEC_RESTORE
	} sec_phase_e;

	// One accepted sleep request.
	typedef struct packed {
		logic       go;
		logic [1:0] state;
	} sec_req_s;

	// Platform power controls driven to the board.
	typedef struct packed {
		logic       cpu_halt;
		logic       clk_stop;
		logic       mem_self_refresh;
		logic       power_off;
	} sec_plane_s;

	// Bus slave state.
	typedef struct packed {
		logic        awvalid_seen;
		logic [11:0] awaddr;
		logic        wvalid_seen;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} sec_axi_s;

endpackage : sec_pkg

// File: core/sec_sleep_ctrl.sv
// Sleep entry control: register slave, type decode, power-plane sequencer and wake logic.
// How it works
// - Each control register carries a three-bit sleep type field.
// - A single sleep enable bit launches entry into the selected state.
// - The type used is the one carried by the write that sets enable.
// - Two control groups exist; each holds its own sleep type value.
// - A software map turns each type code into a hardware sleeping state.
// - Hardware sets the wake status flag while the system sleeps.
// - The processor is halted in every sleeping state, not merely slowed.
// - One to four sleeping states are implemented.
// - Power-plane sequencing starts when the sleep enable bit is set.
// - Prepare-to-sleep housekeeping never starts sequencing by itself.
// - An enabled wake event seen in the asleep phase undoes the sequence and restarts clocks; during the entry steps wakes are ignored.
`timescale 1ns/1ps
`include "sec_consts.svh"

module sec_sleep_ctrl #(
	parameter int WAKE_NUM   = `SEC_WAKE_NUM,
	parameter int STEP_COUNT = `SEC_STEP_CYCLES
) (
	// Clock and reset.
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// AXI4-Lite write address and data.
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [11:0]         s_axi_awaddr,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	// AXI4-Lite write response.
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	output logic [1:0]               s_axi_bresp,
	// AXI4-Lite read.
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	input  wire logic [11:0]         s_axi_araddr,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	// Wake event pins.
	input  wire logic [WAKE_NUM-1:0] wake_pins,
	// Platform controls.
	output sec_pkg::sec_plane_s      plane,
	output logic                     fw_hibernate_req,
	output logic                     sleeping
);

	// Whole module state.
	typedef struct packed {
		sec_pkg::sec_axi_s   axi;
		logic [2:0]          sleep_type_group_one;
		logic [2:0]          sleep_type_group_two;
		logic [WAKE_NUM-1:0] wake_en;
		logic [31:0]         type_map;
		logic                wake_status_flag;
		sec_pkg::sec_phase_e phase;
		logic [1:0]          target;
		logic [15:0]         step_cnt;
		sec_pkg::sec_plane_s plane;
		logic                fw_req;
		logic                awready;
		logic                wready;
		logic                arready;
		logic                sleeping;
	} sec_state_s;

	sec_state_s          state_reg;
	sec_state_s          state_next;
	logic [WAKE_NUM-1:0] wake_sync;
	logic                dec_valid;
	logic [1:0]          dec_state;
	logic                wr_fire;
	logic                rd_fire;
	logic [2:0]          wr_type;

	// Wake pins come from outside this clock domain.
	sec_wake_sync #(
		.WIDTH    (WAKE_NUM)
	) i_sec_wake_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.pin_in   (wake_pins),
		.sync_out (wake_sync)
	);

	// The type decoded is the one in the write being taken, not a stored copy.
	assign wr_type = state_reg.axi.wdata[`SEC_TYPE_MSB:`SEC_TYPE_LSB];

	sec_type_decode i_sec_type_decode (
		.type_code (wr_type),
		.type_map  (state_reg.type_map),
		.valid     (dec_valid),
		.state     (dec_state)
	);

	// A write completes once both halves are held and no earlier answer is waiting.
	assign wr_fire = state_reg.axi.awvalid_seen && state_reg.axi.wvalid_seen
		&& !state_reg.axi.bvalid;
	assign rd_fire = s_axi_arvalid && !state_reg.axi.rvalid;

	// Outputs straight from flip-flops.
	assign s_axi_awready    = state_reg.awready;
	assign s_axi_wready     = state_reg.wready;
	assign s_axi_bvalid     = state_reg.axi.bvalid;
	assign s_axi_bresp      = state_reg.axi.bresp;
	assign s_axi_arready    = state_reg.arready;
	assign s_axi_rvalid     = state_reg.axi.rvalid;
	assign s_axi_rdata      = state_reg.axi.rdata;
	assign s_axi_rresp      = state_reg.axi.rresp;
	assign plane            = state_reg.plane;
	assign fw_hibernate_req = state_reg.fw_req;
	assign sleeping         = state_reg.sleeping;

	// Next-state logic: bus slave, sequencer and wake handling.
	always_comb begin
		logic wake_hit;
		logic step_done;
		wake_hit   = 1'b0;
		step_done  = 1'b0;
		state_next = state_reg;
		state_next.fw_req = 1'b0;
		wake_hit  = |(wake_sync & state_reg.wake_en);
		step_done = (state_reg.step_cnt == 16'(STEP_COUNT - 1));

		// Address and data are caught in either order and held until both arrive.
		if (s_axi_awvalid && s_axi_awready) begin
			state_next.axi.awvalid_seen = 1'b1;
			state_next.axi.awaddr       = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			state_next.axi.wvalid_seen = 1'b1;
			state_next.axi.wdata       = s_axi_wdata;
			state_next.axi.wstrb       = s_axi_wstrb;
		end

		// A complete write updates the targeted register.
		if (wr_fire) begin
			state_next.axi.awvalid_seen = 1'b0;
			state_next.axi.wvalid_seen  = 1'b0;
			state_next.axi.bvalid       = 1'b1;
			state_next.axi.bresp        = `SEC_RESP_OKAY;
			unique case (state_reg.axi.awaddr)
				`SEC_OFF_CTRL_ONE, `SEC_OFF_CTRL_TWO: begin
					if (state_reg.axi.wstrb[1]) begin
						if (state_reg.axi.awaddr == `SEC_OFF_CTRL_ONE) begin
							state_next.sleep_type_group_one = wr_type;
						end else begin
							state_next.sleep_type_group_two = wr_type;
						end
						// Only an enable write can start sequencing, never a type load alone.
						if (state_reg.axi.wdata[`SEC_ENABLE_BIT] && dec_valid
							&& state_reg.phase == sec_pkg::SEC_WORKING) begin
							state_next.target = dec_state;
							state_next.phase  = sec_pkg::SEC_HALT_CPU;
							state_next.step_cnt = 16'h0000;
						end
					end
				end
				`SEC_OFF_STATUS: begin
					// Write one to clear; a wake in the same cycle is set later in this process.
					if (state_reg.axi.wstrb[1] && state_reg.axi.wdata[`SEC_STS_WAKE_BIT]) begin
						state_next.wake_status_flag = 1'b0;
					end
				end
				`SEC_OFF_WAKE_EN: begin
					if (state_reg.axi.wstrb[0]) begin
						state_next.wake_en = state_reg.axi.wdata[WAKE_NUM-1:0];
					end
				end
				`SEC_OFF_TYPE_MAP: begin
					state_next.type_map = state_reg.axi.wdata;
				end
				`SEC_OFF_FW_CMD: begin
					if (state_reg.axi.wstrb[0]
						&& state_reg.axi.wdata[7:0] == `SEC_FW_HIB_VALUE) begin
						state_next.fw_req = 1'b1;
					end
				end
				default: begin
					state_next.axi.bresp = `SEC_RESP_SLVERR;
				end
			endcase
		end
		// The response stands until the master takes it.
		if (state_reg.axi.bvalid && s_axi_bready) begin
			state_next.axi.bvalid = 1'b0;
		end

		// Reads; the enable bit always reads back zero.
		if (rd_fire) begin
			state_next.axi.rvalid = 1'b1;
			state_next.axi.rresp  = `SEC_RESP_OKAY;
			state_next.axi.rdata  = 32'h0000_0000;
			unique case (s_axi_araddr)
				`SEC_OFF_CTRL_ONE: state_next.axi.rdata[`SEC_TYPE_MSB:`SEC_TYPE_LSB] =
					state_reg.sleep_type_group_one;
				`SEC_OFF_CTRL_TWO: state_next.axi.rdata[`SEC_TYPE_MSB:`SEC_TYPE_LSB] =
					state_reg.sleep_type_group_two;
				`SEC_OFF_STATUS: begin
					state_next.axi.rdata[`SEC_STS_WAKE_BIT]   = state_reg.wake_status_flag;
					state_next.axi.rdata[`SEC_STS_ASLEEP_BIT] =
						(state_reg.phase != sec_pkg::SEC_WORKING);
					state_next.axi.rdata[`SEC_STS_STATE_LSB +: 2] = state_reg.target;
				end
				`SEC_OFF_WAKE_EN:  state_next.axi.rdata[WAKE_NUM-1:0] = state_reg.wake_en;
				`SEC_OFF_TYPE_MAP: state_next.axi.rdata = state_reg.type_map;
				`SEC_OFF_FW_CMD:   state_next.axi.rdata = 32'h0000_0000;
				default:           state_next.axi.rresp = `SEC_RESP_SLVERR;
			endcase
		end
		// Read data stand until the master takes them.
		if (state_reg.axi.rvalid && s_axi_rready) begin
			state_next.axi.rvalid = 1'b0;
		end

		// Sequencer: each step waits one step time before the next plane changes.
		if (state_reg.phase != sec_pkg::SEC_WORKING && state_reg.phase != sec_pkg::SEC_ASLEEP) begin
			state_next.step_cnt = step_done ? 16'h0000 : state_reg.step_cnt + 16'h0001;
		end
		// Planes are only added on the way down and only removed on the way up.
		unique case (state_reg.phase)
			sec_pkg::SEC_WORKING: begin
				state_next.plane = '0;
			end
			sec_pkg::SEC_HALT_CPU: begin
				// Halt, not slow down: the processor runs no instructions asleep.
				state_next.plane.cpu_halt = 1'b1;
				if (step_done) begin
					state_next.phase = (state_reg.target == 2'h0) ?
						sec_pkg::SEC_ASLEEP : sec_pkg::SEC_STOP_CLK;
				end
			end
			sec_pkg::SEC_STOP_CLK: begin
				state_next.plane.clk_stop         = 1'b1;
				state_next.plane.mem_self_refresh = 1'b1;
				if (step_done) begin
					state_next.phase = (state_reg.target >= 2'h2) ?
						sec_pkg::SEC_POWER_OFF : sec_pkg::SEC_ASLEEP;
				end
			end
			sec_pkg::SEC_POWER_OFF: begin
				state_next.plane.power_off = 1'b1;
				if (step_done) begin
					state_next.phase = sec_pkg::SEC_ASLEEP;
				end
			end
			sec_pkg::SEC_ASLEEP: begin
				if (wake_hit) begin
					state_next.wake_status_flag = 1'b1;
					state_next.phase            = sec_pkg::SEC_RESTORE;
					state_next.step_cnt         = 16'h0000;
					state_next.plane.power_off  = 1'b0;
				end
			end
			sec_pkg::SEC_RESTORE: begin
				// Clocks restart before the processor is released.
				state_next.plane.clk_stop         = 1'b0;
				state_next.plane.mem_self_refresh = 1'b0;
				if (step_done) begin
					state_next.plane.cpu_halt = 1'b0;
					state_next.phase          = sec_pkg::SEC_WORKING;
				end
			end
			// The two spare phase codes cannot be reached; fall back to working.
			default: begin
				state_next.phase = sec_pkg::SEC_WORKING;
				state_next.plane = '0;
			end
		endcase

		// Ready and sleeping are worked out from the next state so that they leave a
		// flip-flop directly; their timing is that of the state bits behind them.
		state_next.awready  = !state_next.axi.awvalid_seen && !state_next.axi.bvalid;
		state_next.wready   = !state_next.axi.wvalid_seen && !state_next.axi.bvalid;
		state_next.arready  = !state_next.axi.rvalid;
		// The flag keeps sleeping high after a wake until software clears it.
		state_next.sleeping = state_next.wake_status_flag
			|| (state_next.phase == sec_pkg::SEC_ASLEEP);
	end

	// One register for the whole state.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg          <= '0;
			state_reg.type_map <= `SEC_TYPE_MAP_RESET;
			state_reg.phase    <= sec_pkg::SEC_WORKING;
			// An idle slave offers its ready signals straight out of reset.
			state_reg.awready  <= 1'b1;
			state_reg.wready   <= 1'b1;
			state_reg.arready  <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule : sec_sleep_ctrl

// File: core/sec_type_decode.sv
// Decoder from a sleep type code to an implemented hardware sleeping state.
`timescale 1ns/1ps
`include "sec_consts.svh"

module sec_type_decode #(
	parameter int STATES = `SEC_STATE_NUM
) (
	// Code under test and the software-owned map.
	input  wire logic [2:0]  type_code,
	input  wire logic [31:0] type_map,
	// Decoded result.
	output logic             valid,
	output logic [1:0]       state
);

	// Map word holds a valid flag per code in bits 7:0 and state index pairs above.
	always_comb begin
		valid = type_map[type_code];
		state = type_map[8 + 2 * type_code +: 2];
	end

endmodule : sec_type_decode

// File: core/sec_wake_sync.sv
// Two-flop synchronisers for the wake event pins.
`timescale 1ns/1ps

module sec_wake_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset.
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Asynchronous pins and their synchronised copy.
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] first_reg;

	// The first stage feeds the second stage only, so metastability never spreads.
	genvar i;
	for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				first_reg[i] <= 1'b0;
				sync_out[i]  <= 1'b0;
			end else begin
				first_reg[i] <= pin_in[i];
				sync_out[i]  <= first_reg[i];
			end
		end
	end

endmodule : sec_wake_sync

// File: verification/sec_sleep_ctrl_assertions.sv
// Concurrent checks on the ports of the sleep entry control.
`timescale 1ns/1ps

module sec_sleep_ctrl_assertions (
	// Clock and reset.
	input wire logic                aclk,
	input wire logic                aresetn,
	// Register bus.
	input wire logic                s_axi_awvalid,
	input wire logic                s_axi_awready,
	input wire logic                s_axi_wvalid,
	input wire logic                s_axi_wready,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_bready,
	input wire logic [1:0]          s_axi_bresp,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic                s_axi_rvalid,
	input wire logic                s_axi_rready,
	input wire logic [31:0]         s_axi_rdata,
	input wire logic [1:0]          s_axi_rresp,
	// Platform controls.
	input wire sec_pkg::sec_plane_s plane,
	input wire logic                fw_hibernate_req
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// A response must not vanish before the master has taken it.
	property p_bresp_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped early");
	property p_rdata_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata});
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped early");
	property p_write_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write not answered");
	property p_read_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");
	// A second request while one is pending would lose the first answer.
	property p_busy_refuse;
		(s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready);
	endproperty
	a_busy_refuse: assert property (p_busy_refuse) else $error("request taken while busy");
	// Power may be cut only with the processor held.
	property p_halt_under_off;
		plane.power_off || plane.clk_stop |-> plane.cpu_halt;
	endproperty
	a_halt_under_off: assert property (p_halt_under_off) else $error("plane off while cpu runs");
	property p_start_on_write;
		$rose(plane.cpu_halt) |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	a_start_on_write: assert property (p_start_on_write) else $error("halt without write");
	property p_fw_pulse;
		fw_hibernate_req |=> !fw_hibernate_req;
	endproperty
	a_fw_pulse: assert property (p_fw_pulse) else $error("hibernate request too long");
endmodule : sec_sleep_ctrl_assertions

bind sec_sleep_ctrl sec_sleep_ctrl_assertions i_sec_sleep_ctrl_assertions (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.s_axi_rresp, .plane, .fw_hibernate_req);

// File: verification/sec_sleep_ctrl_bench.sv
// Self-checking bench for the sleep entry control.
`timescale 1ns/1ps
`include "sec_consts.svh"

module sec_sleep_ctrl_bench;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, fw_hibernate_req, sleeping;
	logic [11:0]         s_axi_awaddr, s_axi_araddr;
	logic [31:0]         s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]          s_axi_wstrb;
	logic [1:0]          s_axi_bresp, s_axi_rresp, rs, idx;
	logic [7:0]          wake_pins;
	sec_pkg::sec_plane_s plane;
	int                  bad_count, check_count, cycles, fw_pulses, n;
	int                  bad_codes[4] = '{0, 5, 6, 7};

	// Short steps keep the sequencer quick in simulation.
	sec_sleep_ctrl #(.WAKE_NUM(8), .STEP_COUNT(2)) i_sec_sleep_ctrl (.aclk, .aresetn,
		.s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .wake_pins, .plane, .fw_hibernate_req, .sleeping);

	// Clock at 20 MHz.
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// Watchdog and hibernate pulse counter.
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (fw_hibernate_req === 1'b1) fw_pulses <= fw_pulses + 1;
		if (cycles == 20000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Waits end after a falling edge, so outputs are settled when compared.
	task automatic pause(input int k);
		repeat (k) @(negedge aclk);
	endtask : pause

	// Ready is sampled mid-cycle; release follows the edge that took the item.
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_p, w_p, aw_t, w_t, ok;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw_p = 1'b1;
		w_p = 1'b1;
		while (aw_p || w_p) begin
			@(negedge aclk);
			aw_t = s_axi_awready;
			w_t = s_axi_wready;
			@(posedge aclk);
			if (aw_p && aw_t) begin
				s_axi_awvalid <= 1'b0;
				aw_p = 1'b0;
			end
			if (w_p && w_t) begin
				s_axi_wvalid <= 1'b0;
				w_p = 1'b0;
			end
		end
		do begin
			@(negedge aclk);
			ok = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
		end while (!ok);
		s_axi_bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ok;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			ok = s_axi_arready;
			@(posedge aclk);
		end while (!ok);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			ok = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
		end while (!ok);
		s_axi_rready <= 1'b0;
	endtask : axi_read

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		axi_write(a, d, rs);
		check(rs, `SEC_RESP_OKAY);
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		axi_read(a, rd, rs);
		check(rs, `SEC_RESP_OKAY);
		check(rd & m, e);
	endtask : rd_chk

	task automatic tally_and_finish;
		if (bad_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// Main sequence.
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, wake_pins} = '0;
		s_axi_wstrb = 4'hF;
		aresetn = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		pause(1);
		check(plane, 32'h0);
		rd_chk(`SEC_OFF_TYPE_MAP, 32'hFFFF_FFFF, `SEC_TYPE_MAP_RESET);
		axi_write(12'h020, 32'h0000_0001, rs);
		check(rs, `SEC_RESP_SLVERR);
		axi_read(12'h020, rd, rs);
		check(rs, `SEC_RESP_SLVERR);
		check(rd, 32'h0);
		// Codes with no state must leave the system working.
		for (int i = 0; i < 4; i++) begin
			wr(`SEC_OFF_CTRL_ONE, 32'h2000 | (bad_codes[i] << 10));
			pause(10);
			check(plane, 32'h0);
			rd_chk(`SEC_OFF_CTRL_ONE, 32'h2000, 32'h0);
		end
		wr(`SEC_OFF_CTRL_ONE, 32'h3 << 10);
		pause(10);
		check(plane, 32'h0);
		wr(`SEC_OFF_TYPE_MAP, 32'h0003_901E);
		wr(`SEC_OFF_WAKE_EN, 32'h0000_0001);
		// Each state in turn, alternating groups, then a wake.
		for (int c = 1; c <= 4; c++) begin
			idx = 2'(c - 1);
			wr(c[0] ? `SEC_OFF_CTRL_ONE : `SEC_OFF_CTRL_TWO, 32'h2000 | (c << 10));
			n = 0;
			do pause(1); while (sleeping !== 1'b1 && ++n < 200);
			check(plane, {1'b1, idx != 2'h0, idx != 2'h0, idx[1]});
			rd_chk(`SEC_OFF_STATUS, 32'h7, {idx, 1'b1});
			@(posedge aclk);
			wake_pins <= 8'h02;
			pause(12);
			check({sleeping, plane.cpu_halt}, 2'h3);
			// Pin 0 stands for the clock alarm that software armed before sleeping.
			@(posedge aclk);
			wake_pins <= 8'h01;
			n = 0;
			do pause(1); while (plane.cpu_halt !== 1'b0 && ++n < 200);
			check(plane, 32'h0);
			rd_chk(`SEC_OFF_STATUS, 32'h8000, 32'h8000);
			@(posedge aclk);
			wake_pins <= 8'h00;
			pause(6);
			wr(`SEC_OFF_STATUS, 32'h8000);
			pause(4);
			check(sleeping, 1'b0);
			rd_chk(`SEC_OFF_STATUS, 32'h8001, 32'h0);
		end
		// Each group keeps the type of its own last write: three in one, four in two.
		rd_chk(`SEC_OFF_CTRL_ONE, 32'h1C00, 32'h0C00);
		rd_chk(`SEC_OFF_CTRL_TWO, 32'h1C00, 32'h1000);
		wr(`SEC_OFF_FW_CMD, 32'h5A);
		wr(`SEC_OFF_FW_CMD, `SEC_FW_HIB_VALUE);
		pause(4);
		check(fw_pulses, 32'h1);
		tally_and_finish();
	end
endmodule : sec_sleep_ctrl_bench
